// >>> hw/hcwc_pkg.sv
// Constants and types for the host command word codec
package hcwc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_RX_CMD  = 8'h00;
  localparam logic [7:0] OFS_RX_SUB  = 8'h04;
  localparam logic [7:0] OFS_RX_STAT = 8'h08;
  localparam logic [7:0] OFS_TX_CTRL = 8'h0c;
  localparam logic [7:0] OFS_TX_CMD  = 8'h10;
  localparam logic [7:0] OFS_TX_RSP  = 8'h14;
  localparam logic [7:0] OFS_COUNT   = 8'h18;

  // Command word fields
  localparam logic [15:0] GRP_SYSIF  = 16'h8000;
  localparam logic [15:0] GRP_DIO    = 16'h4000;
  localparam logic [15:0] GRP_RFT    = 16'h2000;
  localparam logic [15:0] GRP_TTC    = 16'h1000;
  localparam logic [15:0] GRP_MODE   = 16'h0400;
  localparam logic [15:0] GRP_DIAG   = 16'h0200;
  localparam logic [15:0] GRP_MASK   = 16'hf600;
  localparam logic [15:0] FLG_UNSOL  = 16'h0010;
  localparam logic [15:0] FLG_ACK    = 16'h0001;

  // Response word fields
  localparam logic [15:0] RSP_SYNC   = 16'h8000;
  localparam logic [15:0] RSP_ASYNC  = 16'h4000;
  localparam logic [15:0] RSP_UNSOL  = 16'h2000;
  localparam logic [15:0] RSP_OK     = 16'h0800;
  localparam logic [15:0] RSP_ERR    = 16'h0200;
  localparam logic [15:0] RSP_CTL    = 16'h0100;

  // Codes used when the codec rejects a received command
  localparam logic [7:0] CODE_GRP_ERR = 8'h03;
  localparam logic [7:0] CODE_SUB_ERR = 8'h08;

  // System interface sub-command codes
  localparam logic [15:0] SUB_IDENT   = 16'h0000;
  localparam logic [15:0] SUB_SET_TD  = 16'h0003;
  localparam logic [15:0] SUB_GET_TD  = 16'h0004;
  localparam logic [15:0] SUB_FW_APP  = 16'h0005;
  localparam logic [15:0] SUB_RESET   = 16'h0006;
  localparam logic [15:0] SUB_BUF_GET = 16'h0007;
  localparam logic [15:0] SUB_BUF_CNT = 16'h0008;
  localparam logic [15:0] SUB_BUF_DEL = 16'h0009;
  localparam logic [15:0] SUB_ST_BOOT = 16'h000a;
  localparam logic [15:0] SUB_ST_LANE = 16'h000b;
  localparam logic [15:0] SUB_ST_SYS  = 16'h000c;
  localparam logic [15:0] SUB_SET_BM  = 16'h0016;
  localparam logic [15:0] SUB_GET_BM  = 16'h0017;
  localparam logic [15:0] SUB_SET_TMO = 16'h0018;
  localparam logic [15:0] SUB_GET_TMO = 16'h0019;
  localparam logic [15:0] SUB_SET_SW  = 16'h001a;
  localparam logic [15:0] SUB_GET_SW  = 16'h001b;
  localparam logic [15:0] SUB_FW_PL   = 16'h001c;
  localparam logic [15:0] SUB_FW_BOOT = 16'h001d;
  localparam logic [15:0] SUB_SERIAL  = 16'h001f;
  localparam logic [15:0] SUB_FW_VER  = 16'h0021;
  localparam logic [15:0] SUB_DEFAULT = 16'h002b;
  localparam logic [15:0] SUB_SET_HIP = 16'h0040;
  localparam logic [15:0] SUB_GET_HIP = 16'h0041;
  localparam logic [15:0] SUB_SET_IP  = 16'h0042;
  localparam logic [15:0] SUB_GET_IP  = 16'h0043;
  localparam logic [15:0] SUB_GET_TCP = 16'h0044;

  // Reset values
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [31:0] RST_DATA   = 32'h0000_0000;

  // Outgoing message kinds
  typedef enum logic [1:0] {
    KIND_RSP   = 2'b00,  // Direct command response
    KIND_ASYNC = 2'b01,  // Asynchronous response
    KIND_UNSOL = 2'b10,  // Unsolicited status
    KIND_ACK   = 2'b11   // Data acknowledge
  } hcwc_kind_e;

  // Status classes; the fourth code is the reserved prefix
  typedef enum logic [1:0] {
    STAT_OK  = 2'b00,
    STAT_ERR = 2'b01,
    STAT_CTL = 2'b10,
    STAT_RSV = 2'b11
  } hcwc_stat_e;

endpackage

// >>> hw/hcwc_top.sv
// Host command word codec with APB register access
`timescale 1ns/10ps
module hcwc_top (
  input  wire logic        CORE_CLK_I,  // 125 MHz core clock
  input  wire logic        NRST_I,      // Async reset, active low
  input  wire logic        PSEL_I,      // APB select
  input  wire logic        PENABLE_I,   // APB access phase
  input  wire logic        PWRITE_I,    // APB direction, high = write
  input  wire logic [7:0]  PADDR_I,     // APB byte address
  input  wire logic [31:0] PWDATA_I,    // APB write data
  output logic      [31:0] PRDATA_O,    // APB read data
  output logic             PREADY_O,    // APB ready
  output logic             PSLVERR_O,   // APB error on unmapped address
  output logic      [15:0] TX_CMD_O,    // Composed system command word
  output logic      [15:0] TX_RSP_O,    // Composed system response word
  output logic             TX_STB_O     // One-cycle pulse per new message
);
  import hcwc_pkg::*;

  // All clocked state of the codec except the reset synchroniser
  typedef struct packed {
    logic [15:0] rx_cmd;   // Received command word
    logic [15:0] rx_sub;   // Received sub-command code
    logic [15:0] tx_ctrl;  // Last written message request
    logic [15:0] tx_cmd;   // Composed command word
    logic [15:0] tx_rsp;   // Composed response word
    logic        tx_stb;   // Send pulse
    logic [15:0] tx_cnt;   // Messages composed
    logic [15:0] rej_cnt;  // Responses forced to error
    logic [31:0] rdata;    // Read data for the access phase
    logic        slverr;   // Error for the access phase
  } hcwc_state_s;

  hcwc_state_s st_r;       // Registered state
  hcwc_state_s st_nxt;     // Next state
  logic [1:0]  rst_sync_r; // Reset release synchroniser
  logic        rst_n;      // Synchronised reset

  // Request fields decoded from a write to the control register
  hcwc_kind_e  req_kind;   // Message kind
  hcwc_stat_e  req_stat;   // Requested status class
  logic [2:0]  req_grp;    // Originating group index
  logic [7:0]  req_code;   // Group-specific code
  logic [15:0] grp_bit;    // Group bit for the command word
  logic [15:0] cls_bit;    // Delivery class bit
  logic [15:0] sts_bit;    // Status class bit
  logic [7:0]  out_code;   // Code placed in bits 7..0
  logic        reject;     // Received command is not acceptable
  logic        force_err;  // Response replaced by error

  // Received command decode
  logic        grp_ok;     // Exactly one group bit, no stray upper bit
  logic        sub_known;  // Sub-command is a listed code
  logic        rx_valid;   // Command acceptable as a whole
  logic        setup;      // APB setup phase
  logic        access_wr;  // APB write taking effect this edge

  // One-hot check over the group bits
  function automatic logic one_hot16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'd0, v[i]};
    end
    return (n == 5'd1);
  endfunction

  // Group index to its command word bit; invalid index falls back to
  // the system interface group so the word is never without a group
  function automatic logic [15:0] grp_enc(input logic [2:0] idx);
    logic [15:0] g;
    g = GRP_SYSIF;
    case (idx)
      3'd0: g = GRP_SYSIF;
      3'd1: g = GRP_DIO;
      3'd2: g = GRP_RFT;
      3'd3: g = GRP_TTC;
      3'd4: g = GRP_MODE;
      3'd5: g = GRP_DIAG;
      default: g = GRP_SYSIF;
    endcase
    return g;
  endfunction

  // Listed system interface sub-commands
  function automatic logic sub_listed(input logic [15:0] c);
    logic k;
    k = 1'b0;
    case (c)
      SUB_IDENT, SUB_SERIAL, SUB_FW_VER,
      SUB_SET_TD, SUB_GET_TD:                 k = 1'b1;
      SUB_BUF_GET, SUB_BUF_CNT, SUB_BUF_DEL:  k = 1'b1;
      SUB_SET_BM, SUB_GET_BM,
      SUB_SET_SW, SUB_GET_SW:                 k = 1'b1;
      SUB_SET_TMO, SUB_GET_TMO:               k = 1'b1;
      SUB_FW_APP, SUB_FW_PL, SUB_FW_BOOT:     k = 1'b1;
      SUB_ST_BOOT, SUB_ST_LANE, SUB_ST_SYS:   k = 1'b1;
      SUB_DEFAULT, SUB_RESET:                 k = 1'b1;
      SUB_SET_HIP, SUB_GET_HIP, SUB_SET_IP,
      SUB_GET_IP, SUB_GET_TCP:                k = 1'b1;
      default:                                k = 1'b0;
    endcase
    return k;
  endfunction

  // Reset release through two flip-flops; input side is a constant
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Decode of the command the host has sent
  always_comb begin
    // The host must set one group bit; anything else is a group error
    grp_ok = one_hot16(st_r.rx_cmd & GRP_MASK) &&
             ((st_r.rx_cmd & ~GRP_MASK & 16'hff00) == 16'h0000);
    sub_known = sub_listed(st_r.rx_sub);
    // Sub-command only matters for the system interface group
    if (st_r.rx_cmd[15]) begin
      rx_valid = grp_ok && sub_known;
    end else begin
      rx_valid = grp_ok;
    end
    reject = !rx_valid;
  end

  // Compose the outgoing words from the request being written
  always_comb begin
    req_kind = hcwc_kind_e'(PWDATA_I[1:0]);
    req_stat = hcwc_stat_e'(PWDATA_I[3:2]);
    req_grp  = PWDATA_I[6:4];
    req_code = PWDATA_I[15:8];
    grp_bit  = grp_enc(req_grp);
    // Only direct responses answer a received command
    force_err = (req_kind == KIND_RSP) && reject;
    // Delivery class
    case (req_kind)
      KIND_RSP:   cls_bit = RSP_SYNC;
      KIND_ACK:   cls_bit = RSP_SYNC;
      KIND_ASYNC: cls_bit = RSP_ASYNC;
      KIND_UNSOL: cls_bit = RSP_UNSOL;
      default:    cls_bit = RSP_SYNC;
    endcase
    // Status class; the reserved prefix is never produced
    out_code = req_code;
    if (req_kind == KIND_ACK) begin
      sts_bit = RSP_CTL;
    end else if (force_err) begin
      sts_bit  = RSP_ERR;
      out_code = grp_ok ? CODE_SUB_ERR : CODE_GRP_ERR;
    end else begin
      case (req_stat)
        STAT_OK:  sts_bit = RSP_OK;
        STAT_ERR: sts_bit = RSP_ERR;
        STAT_CTL: sts_bit = RSP_CTL;
        default:  sts_bit = RSP_ERR;
      endcase
    end
  end

  // APB phase decode
  assign setup     = PSEL_I && !PENABLE_I;
  assign access_wr = PSEL_I && PENABLE_I && PWRITE_I;

  // Next-state logic: register writes, message composition, reads
  always_comb begin
    st_nxt        = st_r;
    st_nxt.tx_stb = 1'b0;
    // Writes take effect at the end of the access phase
    if (access_wr) begin
      if (PADDR_I == OFS_RX_CMD) begin
        st_nxt.rx_cmd = PWDATA_I[15:0];
      end else if (PADDR_I == OFS_RX_SUB) begin
        st_nxt.rx_sub = PWDATA_I[15:0];
      end else if (PADDR_I == OFS_TX_CTRL) begin
        // Writing the request sends one message
        st_nxt.tx_ctrl = PWDATA_I[15:0];
        st_nxt.tx_cmd  = grp_bit |
          ((req_kind == KIND_UNSOL) ? FLG_UNSOL : 16'h0000) |
          ((req_kind == KIND_ACK)   ? FLG_ACK   : 16'h0000);
        st_nxt.tx_rsp  = cls_bit | sts_bit | {8'h00, out_code};
        st_nxt.tx_stb  = 1'b1;
        st_nxt.tx_cnt  = st_r.tx_cnt + 16'd1;
        if (force_err) begin
          st_nxt.rej_cnt = st_r.rej_cnt + 16'd1;
        end
      end else if (PADDR_I == OFS_COUNT) begin
        // Any write clears both counters
        st_nxt.tx_cnt  = RST_WORD;
        st_nxt.rej_cnt = RST_WORD;
      end
    end
    // Read data and error are captured in the setup phase so that
    // they come from flops in the access phase
    if (setup) begin
      st_nxt.slverr = 1'b0;
      if (PADDR_I == OFS_RX_CMD) begin
        st_nxt.rdata = {16'h0000, st_r.rx_cmd};
      end else if (PADDR_I == OFS_RX_SUB) begin
        st_nxt.rdata = {16'h0000, st_r.rx_sub};
      end else if (PADDR_I == OFS_RX_STAT) begin
        st_nxt.rdata = {27'd0,
                        (st_r.rx_cmd & FLG_ACK) != 16'h0000,
                        (st_r.rx_cmd & FLG_UNSOL) != 16'h0000,
                        rx_valid, sub_known, grp_ok};
      end else if (PADDR_I == OFS_TX_CTRL) begin
        st_nxt.rdata = {16'h0000, st_r.tx_ctrl};
      end else if (PADDR_I == OFS_TX_CMD) begin
        st_nxt.rdata = {16'h0000, st_r.tx_cmd};
      end else if (PADDR_I == OFS_TX_RSP) begin
        st_nxt.rdata = {16'h0000, st_r.tx_rsp};
      end else if (PADDR_I == OFS_COUNT) begin
        st_nxt.rdata = {st_r.rej_cnt, st_r.tx_cnt};
      end else begin
        // Unmapped address reads zero and flags an error
        st_nxt.rdata  = RST_DATA;
        st_nxt.slverr = 1'b1;
      end
    end
  end

  // State register; a setup read racing a write to the same register
  // cannot happen on APB since phases never overlap
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; slave never inserts wait states
  assign PREADY_O  = 1'b1;
  assign PRDATA_O  = st_r.rdata;
  assign PSLVERR_O = st_r.slverr && PSEL_I && PENABLE_I;
  assign TX_CMD_O  = st_r.tx_cmd;
  assign TX_RSP_O  = st_r.tx_rsp;
  assign TX_STB_O  = st_r.tx_stb;

endmodule

// >>> tb/hcwc_props.sv
// Checker for the codec's bus answers and composed message words
`timescale 1ns/10ps
module hcwc_props (
  input wire logic        CORE_CLK_I, // Core clock
  input wire logic        NRST_I,     // Reset, active low
  input wire logic        PSEL_I,     // APB select
  input wire logic        PENABLE_I,  // APB access phase
  input wire logic        PWRITE_I,   // APB direction
  input wire logic [7:0]  PADDR_I,    // APB byte address
  input wire logic [31:0] PWDATA_I,   // APB write data
  input wire logic [31:0] PRDATA_O,   // APB read data
  input wire logic        PREADY_O,   // APB ready
  input wire logic        PSLVERR_O,  // APB error
  input wire logic [15:0] TX_CMD_O,   // Command word
  input wire logic [15:0] TX_RSP_O,   // Response word
  input wire logic        TX_STB_O    // New message pulse
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // Completed write into the message control word
  sequence s_ctl_wr;
    PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h0c;
  endsequence
  // Same write, for any kind other than a direct response
  sequence s_pass_wr;
    PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h0c &&
    PWDATA_I[1:0] != 2'b00;
  endsequence
  // Access phase outside the seven mapped words
  sequence s_bad_acc;
    PSEL_I && PENABLE_I && (PADDR_I > 8'h18 || PADDR_I[1:0] != 2'b00);
  endsequence
  a_ready_high: assert property (PREADY_O)
    else $error("ready low");
  a_stb_cause: assert property (s_ctl_wr |=> TX_STB_O ##1 !TX_STB_O)
    else $error("strobe not one cycle after control write");
  a_stb_only: assert property (TX_STB_O |-> $past(PSEL_I && PENABLE_I &&
    PWRITE_I && PADDR_I == 8'h0c)) else $error("strobe without write");
  a_err_map: assert property (s_bad_acc |-> PSLVERR_O)
    else $error("no error on unmapped access");
  a_err_none: assert property (PSEL_I && PENABLE_I && PADDR_I <= 8'h18 &&
    PADDR_I[1:0] == 2'b00 |-> !PSLVERR_O) else $error("spurious error");
  a_words_hold: assert property (!TX_STB_O |->
    $stable(TX_CMD_O) && $stable(TX_RSP_O)) else $error("words moved");
  a_grp_onehot: assert property (TX_STB_O |->
    $onehot(TX_CMD_O & 16'hf600) && (TX_CMD_O & 16'h09ee) == 16'h0)
    else $error("command group field not one-hot");
  a_unsol_flag: assert property (TX_STB_O |->
    TX_CMD_O[4] == TX_RSP_O[13]) else $error("unsolicited flag mismatch");
  a_ack_ctl: assert property (TX_STB_O && TX_CMD_O[0] |->
    TX_RSP_O[15:8] == 8'h81 && !TX_CMD_O[4])
    else $error("acknowledge without control class");
  a_class_one: assert property (TX_STB_O |->
    $onehot(TX_RSP_O[15:13]) && $onehot({TX_RSP_O[11], TX_RSP_O[9:8]}) &&
    !TX_RSP_O[12] && !TX_RSP_O[10]) else $error("bad response class");
  a_code_pass: assert property (s_pass_wr |=>
    TX_RSP_O[7:0] == $past(PWDATA_I[15:8])) else $error("code not passed");
endmodule
bind hcwc_top hcwc_props i_hcwc_props (.CORE_CLK_I, .NRST_I, .PSEL_I,
  .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
  .PSLVERR_O, .TX_CMD_O, .TX_RSP_O, .TX_STB_O);

// >>> tb/hcwc_host.sv
// Host model: APB master issuing register transfers to the codec
`timescale 1ns/10ps
module hcwc_host (
  input  wire logic        clk_i,     // Core clock
  input  wire logic [31:0] prdata_i,  // Read data
  input  wire logic        pready_i,  // Ready
  input  wire logic        pslverr_i, // Error
  output logic             psel_o,    // Select
  output logic             penable_o, // Access phase
  output logic             pwrite_o,  // Direction
  output logic      [7:0]  paddr_o,   // Byte address
  output logic      [31:0] pwdata_o   // Write data
);
  // Bus idle at time zero
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  // One transfer, held until ready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    q = prdata_i;
    e = pslverr_i;
    // Released lines show the inverse so stale values cannot pass
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// >>> tb/hcwc_top_test.sv
// Self-checking testbench for the host command word codec
`timescale 1ns/10ps
module hcwc_top_test;
  import hcwc_pkg::*;
  logic        clk, nrst, psel, pen, pwr, rdy, serr, stb; // Pins
  logic [7:0]  addr;          // Byte address
  logic [31:0] wd, rdat;      // Bus data
  logic [15:0] cmd, rsp;      // Message words
  logic [15:0] n_msg, n_rej;  // Expected counters
  logic [15:0] last;          // Last expected command word
  logic [15:0] lrsp, lctl;    // Last expected response and request
  logic        v_q, g_q;      // Expected receive checks
  int          error_cnt = 0; // Mismatches
  int          n_checks = 0;  // Comparisons
  // Group bits by index; 6 and 7 fall back to system interface
  localparam logic [15:0] GB [8] = '{16'h8000, 16'h4000, 16'h2000,
    16'h1000, 16'h0400, 16'h0200, 16'h8000, 16'h8000};
  // First 27 codes are listed, the rest are not
  localparam logic [7:0] SUBS [38] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h16, 8'h17, 8'h18, 8'h19,
    8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f, 8'h21, 8'h2b, 8'h40, 8'h41, 8'h42,
    8'h43, 8'h44, 8'h01, 8'h02, 8'h11, 8'h15, 8'h1e, 8'h20, 8'h22, 8'h29,
    8'h2a, 8'h45, 8'hff};
  // Receive words and the status each must give (sub code unlisted)
  localparam logic [15:0] CMDS [7] = '{16'h8400, 16'h0800, 16'h8100,
    16'h4000, 16'h4011, 16'h8000, 16'h0201};
  localparam logic [7:0] STATS [7] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h1d,
    8'h01, 8'h15};
  hcwc_top i_hcwc_top (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wd),
    .PRDATA_O(rdat), .PREADY_O(rdy), .PSLVERR_O(serr), .TX_CMD_O(cmd),
    .TX_RSP_O(rsp), .TX_STB_O(stb));
  hcwc_host i_hcwc_host (.clk_i(clk), .prdata_i(rdat), .pready_i(rdy),
    .pslverr_i(serr), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(addr), .pwdata_o(wd));
  // Compare one value, case equality so unknowns fail
  task automatic chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Bus wrappers over the host model
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic e);
    i_hcwc_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    i_hcwc_host.xfer(1'b1, a, d, q, e);
  endtask
  // Compose one message and judge both words 1 ns after the edge that completes the write
  task automatic send(input logic [1:0] k, s, input logic [2:0] g,
                      input logic [7:0] c);
    logic [15:0] ec, er;
    ec = GB[g] | (k == 2'd2 ? 16'h0010 : 16'h0) | (k == 2'd3);
    er = k == 2'd1 ? 16'h4000 : k == 2'd2 ? 16'h2000 : 16'h8000;
    if (k == 2'd3) er |= {8'h01, c};
    else if (k == 2'd0 && !v_q) er |= {8'h02, g_q ? 8'h08 : 8'h03};
    else er |= {s == 2'd0 ? 8'h08 : s == 2'd2 ? 8'h01 : 8'h02, c};
    n_msg++;
    if (k == 2'd0 && !v_q) n_rej++;
    wr(8'h0c, {16'h0, c, 1'b0, g, s, k});
    #1;
    chk("strobe", 1, stb);
    chk("cmd", ec, cmd);
    chk("rsp", er, rsp);
    last = ec;
    lrsp = er;
    lctl = {c, 1'b0, g, s, k};
  endtask
  // Reset values
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    chk("cmd", 0, cmd);
    chk("rsp", 0, rsp);
    chk("strobe", 0, stb);
    rd(8'h18, q, e);
    chk("count", 0, q);
    rd(8'h00, q, e);
    chk("rxcmd", 0, q);
    $display("test reset done");
  endtask
  // Reset in mid-run clears composed words, counters and the receive command word
  task automatic t_rerun;
    send(2'd1, 2'd0, 3'd2, 8'h77);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    $display("test mid-run reset done");
  endtask
  // Every kind with every status, all group indices
  task automatic t_kinds;
    wr(8'h00, 32'h8000);
    wr(8'h04, 32'h0000);
    for (int i = 0; i < 16; i++) send(i[3:2], i[1:0], 3'(i), 8'(i * 17));
    $display("test kinds done");
  endtask
  // Listed and unlisted sub-commands, then a direct response
  task automatic t_subs;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 38; i++) begin
      wr(8'h04, {24'h0, SUBS[i]});
      rd(8'h08, q, e);
      chk("stat", i < 27 ? 7 : 1, q);
      v_q = i < 27;
      send(2'd0, 2'd0, 3'd0, 8'h5a);
    end
    $display("test subs done");
  endtask
  // Malformed and well-formed receive words
  task automatic t_grp;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, {16'h0, CMDS[i]});
      rd(8'h08, q, e);
      chk("stat", STATS[i], q);
      g_q = STATS[i][0];
      v_q = STATS[i][2];
      send(2'd0, 2'd1, 3'd1, 8'hc3);
    end
    $display("test groups done");
  endtask
  // Unmapped and read-only places, counters and their clear
  task automatic t_bus;
    logic [31:0] q;
    logic        e;
    rd(8'h1c, q, e);
    chk("err", 1, e);
    chk("rdata", 0, q);
    wr(8'h1c, 32'hffff_ffff);
    wr(8'h10, 32'h0000_1234);
    rd(8'h10, q, e);
    chk("txcmd", last, q);
    chk("err", 0, e);
    rd(8'h14, q, e);
    chk("txrsp", lrsp, q);
    rd(8'h0c, q, e);
    chk("txctl", lctl, q);
    rd(8'h05, q, e);
    chk("err", 1, e);
    rd(8'h00, q, e);
    chk("rxcmd", 32'h0201, q);
    rd(8'h18, q, e);
    chk("count", {n_rej, n_msg}, q);
    wr(8'h18, 32'h0);
    rd(8'h18, q, e);
    chk("count", 0, q);
    $display("test bus done");
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    {n_msg, n_rej, v_q, g_q} = {32'h0, 2'b11};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_kinds;
    t_subs;
    t_grp;
    t_bus;
    t_rerun;
    print_verdict;
  end
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule
